// File: hdl/dxo_pkg.sv
// package for the direction-load and exclusive-or execute block
// assumes a 14-bit instruction word and an 8-bit data path
package dxo_pkg;

  // ----------------------------------------------------------------
  // instruction encodings
  // ----------------------------------------------------------------
  localparam logic [13:0] DIR_LOAD_MASK  = 14'h3FF8; // upper bits fixed
  localparam logic [13:0] DIR_LOAD_CODE  = 14'h0060; // 00 0000 0110 0fff
  localparam logic [5:0]  XOR_LIT_CODE   = 6'h3A;    // 11 1010 kkkk kkkk
  localparam logic [5:0]  XOR_FILE_CODE  = 6'h06;    // 00 0110 dfff ffff
  localparam int          OPC_HI         = 13;       // opcode field top
  localparam int          OPC_LO         = 8;        // opcode field bottom
  localparam int          DEST_BIT       = 7;        // destination select
  localparam logic [2:0]  DIR_SEL_MIN    = 3'h5;     // lowest direction reg
  localparam logic [2:0]  DIR_SEL_MAX    = 3'h7;     // highest direction reg
  localparam int          DIR_COUNT      = 3;        // direction registers

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic [7:0]  DIR_RESET      = 8'hFF;    // all pins input
  localparam logic        ZERO_RESET     = 1'b0;     // zero flag clear
  localparam logic [6:0]  FADDR_RESET    = 7'h00;    // file address
  localparam logic [7:0]  FDATA_RESET    = 8'h00;    // file write data

  // ----------------------------------------------------------------
  // phase sequencer, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_DECODE  = 4'b0001,
    PH_READ    = 4'b0010,
    PH_PROCESS = 4'b0100,
    PH_WRITE   = 4'b1000
  } dxo_phase_t;

  // operation selected at decode
  typedef enum logic [3:0] {
    OP_NONE    = 4'b0001,
    OP_DIRLOAD = 4'b0010,
    OP_XORLIT  = 4'b0100,
    OP_XORFILE = 4'b1000
  } dxo_op_t;

endpackage

// File: hdl/dxo_phase_gen.sv
// four-phase instruction cycle sequencer
// assumes a free-running core clock gated by a clock enable
`timescale 1ns/1ps
module dxo_phase_gen (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  output dxo_pkg::dxo_phase_t    phase_o
);

  // ----------------------------------------------------------------
  // phase rotation
  // ----------------------------------------------------------------
  dxo_pkg::dxo_phase_t phase_q;  // current phase
  dxo_pkg::dxo_phase_t phase_d;  // next phase

  // next phase: rotate through the four quarters
  always_comb begin
    phase_d = phase_q;
    if (ce_i) begin
      unique case (phase_q)
        dxo_pkg::PH_DECODE:  phase_d = dxo_pkg::PH_READ;
        dxo_pkg::PH_READ:    phase_d = dxo_pkg::PH_PROCESS;
        dxo_pkg::PH_PROCESS: phase_d = dxo_pkg::PH_WRITE;
        dxo_pkg::PH_WRITE:   phase_d = dxo_pkg::PH_DECODE;
        default:             phase_d = dxo_pkg::PH_DECODE; // illegal code recovery
      endcase
    end
  end

  // register only; reset starts at decode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= dxo_pkg::PH_DECODE;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase_o = phase_q;

endmodule

// File: hdl/dxo_exec.sv
// execute unit for direction-load and the two exclusive-or instructions
// assumes the fetch logic holds instr_i steady for a whole instruction cycle
// and the file register array answers file_rdata_i combinationally
// and that neighbours share ce_i, since a low enable holds every flop
// here, strobes included
`timescale 1ns/1ps
module dxo_exec (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [13:0] instr_i,       // current instruction word
  input  wire logic [7:0]  file_rdata_i,  // addressed file register data
  input  wire logic        dir_we_i,      // direct write to a direction reg
  input  wire logic [1:0]  dir_sel_i,     // which direction reg, 0..2
  input  wire logic [7:0]  dir_wdata_i,   // direct write data
  output logic      [6:0]  file_addr_o,   // file register address
  output logic             file_re_o,     // file read strobe
  output logic             file_we_o,     // file write strobe
  output logic      [7:0]  file_wdata_o,  // file write data
  output logic      [7:0]  acc_o,         // working accumulator
  output logic             zero_o,        // zero flag
  output logic             zero_we_o,     // zero flag updated this cycle
  output logic      [7:0]  dir5_o,        // direction register 5
  output logic      [7:0]  dir6_o,        // direction register 6
  output logic      [7:0]  dir7_o,        // direction register 7
  output logic             done_o         // instruction retired pulse
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // classify an instruction word
  function automatic dxo_pkg::dxo_op_t decode_op(input logic [13:0] w);
    dxo_pkg::dxo_op_t op;
    op = dxo_pkg::OP_NONE;
    if ((w & dxo_pkg::DIR_LOAD_MASK) == dxo_pkg::DIR_LOAD_CODE &&
        w[2:0] >= dxo_pkg::DIR_SEL_MIN && w[2:0] <= dxo_pkg::DIR_SEL_MAX) begin
      op = dxo_pkg::OP_DIRLOAD;
    end else if (w[dxo_pkg::OPC_HI:dxo_pkg::OPC_LO] == dxo_pkg::XOR_LIT_CODE) begin
      op = dxo_pkg::OP_XORLIT;
    end else if (w[dxo_pkg::OPC_HI:dxo_pkg::OPC_LO] == dxo_pkg::XOR_FILE_CODE) begin
      op = dxo_pkg::OP_XORFILE;
    end
    return op;
  endfunction

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  // the sequencer shares ce_i, so a freeze stops both halves together
  dxo_pkg::dxo_phase_t phase;  // current quarter of the cycle

  dxo_phase_gen u_phase (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .phase_o (phase)
  );

  // ----------------------------------------------------------------
  // datapath state
  // ----------------------------------------------------------------
  localparam int    DIRS = dxo_pkg::DIR_COUNT;  // direction registers 5..7
  dxo_pkg::dxo_op_t op_q, op_d;         // latched operation
  logic [7:0]       opnd_q, opnd_d;     // operand read in second phase
  logic [7:0]       res_q, res_d;       // computed result
  logic [7:0]       acc_q, acc_d;       // working accumulator
  logic             zero_q, zero_d;     // zero flag
  logic             zwe_q, zwe_d;       // zero update pulse
  logic [7:0]       dir_q [DIRS];       // direction registers 5..7
  logic [7:0]       dir_d [DIRS];
  logic [6:0]       fa_q, fa_d;         // file address
  logic             fre_q, fre_d;       // file read strobe
  logic             fwe_q, fwe_d;       // file write strobe
  logic [7:0]       fwd_q, fwd_d;       // file write data
  logic             done_q, done_d;     // retire pulse
  // only meaningful for a legal direction-load; other words ignore it
  logic [1:0]       dsel;               // direction index from instruction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // next-state for the whole execute pipeline
  always_comb begin
    op_d   = op_q;
    opnd_d = opnd_q;
    res_d  = res_q;
    acc_d  = acc_q;
    zero_d = zero_q;
    fa_d   = fa_q;
    fwd_d  = fwd_q;
    // strobes last one enabled cycle; with ce_i low they hold as well,
    // otherwise a pulse could vanish before a gated neighbour sees it
    zwe_d  = ce_i ? 1'b0 : zwe_q;
    fre_d  = ce_i ? 1'b0 : fre_q;
    fwe_d  = ce_i ? 1'b0 : fwe_q;
    done_d = ce_i ? 1'b0 : done_q;
    dsel   = 2'(instr_i[2:0] - dxo_pkg::DIR_SEL_MIN);
    for (int i = 0; i < DIRS; i++) begin
      dir_d[i] = dir_q[i];
    end
    // direct file-space write to a direction register; the instruction
    // path below overrides it if both hit the same register in the same cycle
    // a select of 3 names no register and is dropped
    if (ce_i && dir_we_i && dir_sel_i < 2'(DIRS)) begin
      dir_d[dir_sel_i] = dir_wdata_i;
    end
    if (ce_i) begin
      unique case (phase)
        dxo_pkg::PH_DECODE: begin
          // opcode classified once here and held for the later quarters
          op_d = decode_op(instr_i);
          fa_d = instr_i[6:0];
          // start the file read so data is ready in the next quarter
          fre_d = (decode_op(instr_i) == dxo_pkg::OP_XORFILE);
        end
        dxo_pkg::PH_READ: begin
          // literal sits in the low byte; file data for the register form
          opnd_d = (op_q == dxo_pkg::OP_XORFILE) ? file_rdata_i
                                                 : instr_i[7:0];
        end
        dxo_pkg::PH_PROCESS: begin
          // one shared xor serves both forms; other words waste the result
          res_d = acc_q ^ opnd_q;
        end
        dxo_pkg::PH_WRITE: begin
          done_d = 1'b1;
          unique case (op_q)
            dxo_pkg::OP_DIRLOAD: begin
              // no flag touched by the legacy load
              // decode lets only f = 5..7 through, so dsel stays 0..2
              dir_d[dsel] = acc_q;
            end
            dxo_pkg::OP_XORLIT: begin
              acc_d  = res_q;
              zero_d = (res_q == 8'h00);
              zwe_d  = 1'b1;
            end
            dxo_pkg::OP_XORFILE: begin
              zero_d = (res_q == 8'h00);
              zwe_d  = 1'b1;
              // destination bit read live; fetch holds the word all cycle
              if (instr_i[dxo_pkg::DEST_BIT]) begin
                fwe_d = 1'b1;
                fwd_d = res_q;
              end else begin
                acc_d = res_q;
              end
            end
            default: done_d = 1'b1;  // foreign opcode: just retire
          endcase
        end
        // a corrupt phase code drops the word rather than half-run it
        default: op_d = dxo_pkg::OP_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_q   <= dxo_pkg::OP_NONE;
      opnd_q <= dxo_pkg::ACC_RESET;
      res_q  <= dxo_pkg::ACC_RESET;
      acc_q  <= dxo_pkg::ACC_RESET;
      zero_q <= dxo_pkg::ZERO_RESET;
      // strobes drop on reset so no stray write follows it
      zwe_q  <= 1'b0;
      fa_q   <= dxo_pkg::FADDR_RESET;
      fre_q  <= 1'b0;
      fwe_q  <= 1'b0;
      fwd_q  <= dxo_pkg::FDATA_RESET;
      done_q <= 1'b0;
      for (int i = 0; i < DIRS; i++) begin
        dir_q[i] <= dxo_pkg::DIR_RESET;
      end
    end else begin
      // ce_i gating lives in the next-state logic, so this stays plain
      op_q   <= op_d;
      opnd_q <= opnd_d;
      res_q  <= res_d;
      acc_q  <= acc_d;
      zero_q <= zero_d;
      zwe_q  <= zwe_d;
      fa_q   <= fa_d;
      fre_q  <= fre_d;
      fwe_q  <= fwe_d;
      fwd_q  <= fwd_d;
      done_q <= done_d;
      for (int i = 0; i < DIRS; i++) begin
        dir_q[i] <= dir_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  // pulses stand one enabled cycle; levels stand until the next write
  assign file_addr_o  = fa_q;
  assign file_re_o    = fre_q;
  assign file_we_o    = fwe_q;
  assign file_wdata_o = fwd_q;
  assign acc_o        = acc_q;
  assign zero_o       = zero_q;
  assign zero_we_o    = zwe_q;
  assign dir5_o       = dir_q[0];
  assign dir6_o       = dir_q[1];
  assign dir7_o       = dir_q[2];
  assign done_o       = done_q;

endmodule

// File: dv/dxo_exec_properties.sv
// concurrent checks on the execute block ports
// assumes one instruction retires every four enabled clocks;
// checks pause while ce_i is low and the block is frozen
`timescale 1ns/1ps
module dxo_exec_chk (
  input logic        clk_i,
  input logic        rst_i,
  input logic        ce_i,
  input logic [13:0] instr_i,
  input logic [6:0]  file_addr_o,
  input logic        file_re_o,
  input logic        file_we_o,
  input logic [7:0]  file_wdata_o,
  input logic [7:0]  acc_o,
  input logic        zero_o,
  input logic        zero_we_o,
  input logic [7:0]  dir5_o,
  input logic        done_o
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  a_done_one_cycle: assert property (done_o |=> !done_o)
    else $error("done pulse too long");
  a_read_then_done: assert property (file_re_o |-> ##3 done_o)
    else $error("retire not three cycles after read");
  a_read_addr_field: assert property (file_re_o |-> file_addr_o == instr_i[6:0])
    else $error("file address wrong");
  // acc four cycles back is the value before decode
  a_lit_xor_result: assert property (done_o
    && $past(instr_i[13:8]) == dxo_pkg::XOR_LIT_CODE
    |-> acc_o == ($past(acc_o, 4) ^ $past(instr_i[7:0])))
    else $error("literal xor result wrong");
  a_acc_zero_flag: assert property (zero_we_o && !file_we_o
    |-> zero_o == (acc_o == 8'h00))
    else $error("zero flag disagrees with accumulator");
  a_file_dest_write: assert property (file_we_o |-> zero_we_o && $stable(acc_o)
    && zero_o == (file_wdata_o == 8'h00))
    else $error("file destination write wrong");
  a_dir_no_flag: assert property (done_o
    && ($past(instr_i) & dxo_pkg::DIR_LOAD_MASK) == dxo_pkg::DIR_LOAD_CODE
    |-> !zero_we_o && $stable(zero_o))
    else $error("direction load touched zero flag");
  a_dir_copy_acc: assert property (done_o
    && $past(instr_i) == (dxo_pkg::DIR_LOAD_CODE | 14'h0005) |-> dir5_o == acc_o)
    else $error("direction register not loaded");
  c_file_write: cover property (file_we_o);
  c_zero_set: cover property (done_o && zero_o);
  c_file_read: cover property (file_re_o);
endmodule
bind dxo_exec dxo_exec_chk dxo_exec_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i),
  .ce_i(ce_i), .file_addr_o(file_addr_o), .file_re_o(file_re_o), .file_we_o(file_we_o),
  .file_wdata_o(file_wdata_o), .acc_o(acc_o), .zero_o(zero_o), .zero_we_o(zero_we_o),
  .dir5_o(dir5_o), .done_o(done_o));

// File: dv/tb.sv
// self-checking bench for the execute block
// assumes the block retires one instruction per four enabled clocks
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [13:0] ins; logic [7:0] rd; logic [7:0] acc; logic z; logic fwe; logic [7:0] wd;
  } dxo_row_t;
  logic        clk_i, rst_i, ce_i, dir_we_i, file_re_o, file_we_o, zero_o, zero_we_o, done_o;
  logic [13:0] instr_i;
  logic [7:0]  file_rdata_i, dir_wdata_i, file_wdata_o, acc_o, dir5_o, dir6_o, dir7_o;
  logic [6:0]  file_addr_o;
  logic [1:0]  dir_sel_i;
  int          err_total, checked, cyc;
  // ----------------------------------------------------------------
  // rows: instruction, file data, then expected acc, zero, write, data
  // ----------------------------------------------------------------
  localparam dxo_row_t rows [0:14] = '{
    '{14'h3ab5, 8'h00, 8'hb5, 1'b0, 1'b0, 8'h00}, '{14'h3aaf, 8'h00, 8'h1a, 1'b0, 1'b0, 8'h00},
    '{14'h3a1a, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00}, '{14'h3ab5, 8'h00, 8'hb5, 1'b0, 1'b0, 8'h00},
    '{14'h06ff, 8'haf, 8'hb5, 1'b0, 1'b1, 8'h1a}, '{14'h0600, 8'hb5, 8'h00, 1'b1, 1'b0, 8'h00},
    '{14'h3aff, 8'h00, 8'hff, 1'b0, 1'b0, 8'h00}, '{14'h0690, 8'hff, 8'hff, 1'b1, 1'b1, 8'h00},
    '{14'h3a0f, 8'h00, 8'hf0, 1'b0, 1'b0, 8'h00}, '{14'h06a0, 8'hf0, 8'hf0, 1'b1, 1'b1, 8'h00},
    '{14'h0065, 8'h00, 8'hf0, 1'b1, 1'b0, 8'h00}, '{14'h3a33, 8'h00, 8'hc3, 1'b0, 1'b0, 8'h00},
    '{14'h0067, 8'h00, 8'hc3, 1'b0, 1'b0, 8'h00}, '{14'h3a00, 8'h00, 8'hc3, 1'b0, 1'b0, 8'h00},
    '{14'h0064, 8'h00, 8'hc3, 1'b0, 1'b0, 8'h00}};
  dxo_exec dxo_exec_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .instr_i(instr_i),
    .file_rdata_i(file_rdata_i), .dir_we_i(dir_we_i), .dir_sel_i(dir_sel_i),
    .dir_wdata_i(dir_wdata_i), .file_addr_o(file_addr_o), .file_re_o(file_re_o),
    .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .acc_o(acc_o), .zero_o(zero_o),
    .zero_we_o(zero_we_o), .dir5_o(dir5_o), .dir6_o(dir6_o), .dir7_o(dir7_o), .done_o(done_o));
  // ----------------------------------------------------------------
  // clock, hang guard and helpers
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // a run is about 80 clocks, so 1000 means a hang
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // caller stands just after an edge; four edges retire the word
  task automatic run(input logic [13:0] ins, input logic [7:0] rd);
    instr_i = ins;
    file_rdata_i = rd;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  task tally_and_finish;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_i, ce_i} = 2'b11;
    {dir_we_i, dir_sel_i, dir_wdata_i, instr_i, file_rdata_i} = '0;
    repeat (5) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk("acc_rst", acc_o, 8'h00);
    chk("dir6_rst", dir6_o, 8'hff);
    foreach (rows[i]) begin
      run(rows[i].ins, rows[i].rd);
      chk("done", done_o, 8'h01);
      chk("acc", acc_o, rows[i].acc);
      chk("zero", zero_o, rows[i].z);
      chk("zero_we", zero_we_o, rows[i].ins[13:8] != 6'h00);
      chk("file_we", file_we_o, rows[i].fwe);
      if (rows[i].fwe) chk("wdata", file_wdata_o, rows[i].wd);
    end
    chk("dir5", dir5_o, 8'hf0);
    chk("dir6", dir6_o, 8'hff);
    chk("dir7", dir7_o, 8'hc3);
    // direct write while a no-op word keeps retiring
    {dir_we_i, dir_sel_i, dir_wdata_i} = {1'b1, 2'd1, 8'h5a};
    @(posedge clk_i);
    #1 dir_we_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk("dir6_direct", dir6_o, 8'h5a);
    // file xor into the accumulator, frozen for two clocks after decode
    instr_i = 14'h0645;
    file_rdata_i = 8'h3c;
    @(posedge clk_i);
    #1 chk("file_re", file_re_o, 8'h01);
    chk("file_addr", file_addr_o, 8'h45);
    ce_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk("re_frozen", file_re_o, 8'h01);
    chk("acc_frozen", acc_o, 8'hc3);
    ce_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk("acc_file", acc_o, 8'hff);
    chk("zero_file", zero_o, 8'h00);
    chk("file_we_d0", file_we_o, 8'h00);
    chk("done_file", done_o, 8'h01);
    // reset in mid instruction, then a clean restart
    instr_i = 14'h3a55;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b1;
    @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk("acc_mid_rst", acc_o, 8'h00);
    chk("dir7_mid_rst", dir7_o, 8'hff);
    run(14'h3a55, 8'h00);
    chk("acc_after", acc_o, 8'h55);
    tally_and_finish();
  end
endmodule
